// ===== verilog/system_reset_sequencer.sv
// reset source collection, boot sequence and program flag register
`timescale 1ns/1ns
module system_reset_sequencer
   import reset_seq_pkg::*;
#(
   parameter int warm_rc = rc_warm_cycles,
   parameter int warm_xtal = xtal_warm_cycles,
   parameter int filt_depth = 4
)
(
   input wire logic hclk, // system clock
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // response, always okay
   input wire logic power_up, // supply detector: power-on event
   input wire logic supply_ok, // supply risen and stable
   input wire logic low_voltage, // brown-out reset detect
   input wire logic lv_mid_in, // mid-level supply flag detect
   input wire logic lv_high_in, // high-level supply flag detect
   input wire logic wdt_overflow, // watchdog overflow status
   input wire logic reset_n_pin, // external reset pin, active low
   input wire logic pin_enable, // reset pin function enabled
   input wire logic osc_xtal, // oscillator is a crystal
   output logic core_reset, // hold core in reset
   output logic [11:0] pc_start, // program counter start value
   output logic fetch_enable, // instruction fetch allowed
   output logic low_power_n // low when low-power mode allowed
);
   localparam int tw = 24;
   logic pin_level;
   logic pin_low;
   logic wd_evt;
   logic pw_evt;
   logic any_evt;
   logic tmr_load;
   logic [tw-1:0] tmr_count;
   logic tmr_done;
   seq_state_type state_q;
   seq_state_type state_d;
   logic [7:0] flag_q;
   logic [7:0] flag_d;
   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic wr_q;
   logic wr_d;
   logic rd_q;
   logic rd_d;
   logic [7:0] addr_q;
   logic [7:0] addr_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   initial
   begin
      if (warm_rc < 1 || warm_xtal < warm_rc || warm_xtal >= (1 << tw))
      begin
         $error("warm-up counts out of range");
      end
   end

   pin_filter #(
      .depth(filt_depth)
   ) u_filter (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(reset_n_pin),
      .pin_level(pin_level)
   );

   seq_timer #(
      .width(tw)
   ) u_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(tmr_load),
      .count(tmr_count),
      .done(tmr_done)
   );

   assign pin_low = pin_enable && !pin_level;
   assign wd_evt = wdt_overflow;
   assign pw_evt = power_up || low_voltage || !supply_ok;
   assign any_evt = pw_evt || wd_evt || pin_low;

   function automatic logic [tw-1:0] cyc(input int n);
      cyc = tw'(n);
   endfunction

   // sequence; every reset source re-enters from the top
   always_comb
   begin
      state_d = state_q;
      tmr_load = 1'b0;
      tmr_count = '0;
      unique case (state_q)
         st_power:
         begin
            if (!supply_ok)
            begin
               tmr_load = 1'b1;
               tmr_count = cyc(stable_cycles);
            end
            else if (tmr_done)
            begin
               state_d = st_pin;
            end
         end
         st_pin:
         begin
            if (!pin_low)
            begin
               state_d = st_init;
               tmr_load = 1'b1;
               tmr_count = cyc(init_cycles);
            end
         end
         st_init:
         begin
            if (tmr_done)
            begin
               state_d = st_warm;
               tmr_load = 1'b1;
               tmr_count = osc_xtal ? cyc(warm_xtal) : cyc(warm_rc);
            end
         end
         st_warm:
         begin
            if (tmr_done)
            begin
               state_d = st_run;
            end
         end
         st_run:
         begin
            state_d = st_run;
         end
         st_hold:
         begin
            if (!any_evt)
            begin
               state_d = st_power;
               tmr_load = 1'b1;
               tmr_count = cyc(stable_cycles);
            end
         end
      endcase
      // a live reset source always wins over the sequence
      if (any_evt)
      begin
         state_d = (pw_evt && !power_up && !low_voltage) ? st_power : st_hold;
         tmr_load = 1'b1;
         tmr_count = cyc(stable_cycles);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q <= st_power;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // core side outputs, registered so release is clean
   logic run_q;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         run_q <= 1'b0;
      end
      else
      begin
         run_q <= (state_d == st_run);
      end
   end

   assign core_reset = !run_q;
   assign fetch_enable = run_q;
   assign pc_start = 12'h000;
   assign low_power_n = 1'b1; // boot always ends in normal mode

   // ahb-lite address phase capture
   always_comb
   begin
      wr_d = 1'b0;
      rd_d = 1'b0;
      addr_d = addr_q;
      if (hsel && hready && htrans[1])
      begin
         wr_d = hwrite;
         rd_d = !hwrite;
         addr_d = haddr[9:2]; // offsets are word indexes, byte address is four times
      end
   end

   // flag register and control register
   always_comb
   begin
      flag_d = flag_q;
      ctrl_d = ctrl_q;
      flag_d[lv_mid_bit] = lv_mid_in;
      flag_d[lv_high_bit] = lv_high_in;
      if (wr_q && addr_q == flag_reg_offset)
      begin
         flag_d = (flag_q & ~flag_rw_mask) | (hwdata[7:0] & flag_rw_mask);
         flag_d[lv_mid_bit] = lv_mid_in;
         flag_d[lv_high_bit] = lv_high_in;
      end
      if (wr_q && addr_q == ctrl_reg_offset)
      begin
         ctrl_d = hwdata;
      end
      // hardware cause capture beats a software write in the same cycle
      if (any_evt && state_q != st_hold)
      begin
         flag_d[2:0] = 3'h0;
         ctrl_d = ctrl_reset;
         if (pin_low)
         begin
            flag_d[cause_hi_bit:cause_lo_bit] = cause_external;
         end
         else if (pw_evt)
         begin
            flag_d[cause_hi_bit:cause_lo_bit] = cause_power;
         end
         else
         begin
            flag_d[cause_hi_bit:cause_lo_bit] = cause_watchdog;
         end
      end
      if (low_voltage)
      begin
         flag_d[lv_mid_bit] = 1'b0;
         flag_d[lv_high_bit] = 1'b0;
      end
   end

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (rd_d && addr_d == flag_reg_offset)
      begin
         rdata_d = {24'h00_0000, flag_d};
      end
      else if (rd_d && addr_d == ctrl_reg_offset)
      begin
         rdata_d = ctrl_d;
      end
      else if (rd_d && addr_d == stat_reg_offset)
      begin
         rdata_d = {26'h000_0000, state_d};
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         flag_q <= flag_reset;
         ctrl_q <= ctrl_reset;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         flag_q <= flag_d;
         ctrl_q <= ctrl_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         addr_q <= addr_d;
         rdata_q <= rdata_d;
      end
   end

   // zero wait states; unmapped reads return zero
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
endmodule

// ===== verilog/reset_seq_pkg.sv
// constants and types shared by the system reset sequencer
package reset_seq_pkg;
   localparam logic [7:0] flag_reg_offset = 8'h86;
   localparam logic [7:0] ctrl_reg_offset = 8'h88;
   localparam logic [7:0] stat_reg_offset = 8'h8C;
   localparam int cause_hi_bit = 7;
   localparam int cause_lo_bit = 6;
   localparam int lv_high_bit = 5;
   localparam int lv_mid_bit = 4;
   localparam logic [1:0] cause_watchdog = 2'h0;
   localparam logic [1:0] cause_power = 2'h2;
   localparam logic [1:0] cause_external = 2'h3;
   localparam logic [7:0] flag_reset = 8'hC0;
   localparam logic [7:0] flag_rw_mask = 8'hC7;
   localparam int clk_mhz = 125;
   localparam int rc_warm_us = 32;
   localparam int xtal_warm_us = 4000;
   localparam int rc_warm_cycles = rc_warm_us * clk_mhz;
   localparam int xtal_warm_cycles = xtal_warm_us * clk_mhz;
   localparam int stable_cycles = 16;
   localparam int init_cycles = 4;
   localparam logic [31:0] ctrl_reset = 32'h0000_0000;
   typedef enum logic [5:0]
   {
      st_power = 6'b000001,
      st_pin = 6'b000010,
      st_init = 6'b000100,
      st_warm = 6'b001000,
      st_run = 6'b010000,
      st_hold = 6'b100000
   } seq_state_type;
endpackage

// ===== verilog/seq_timer.sv
// down counter that measures one step of the reset sequence
`timescale 1ns/1ns
module seq_timer
   import reset_seq_pkg::*;
#(
   parameter int width = 20
)
(
   input wire logic hclk, // system clock
   input wire logic hresetn, // async reset, active low
   input wire logic load, // start a new count
   input wire logic [width-1:0] count, // cycles to wait
   output logic done // count has run out
);
   logic [width-1:0] cnt_q;
   logic [width-1:0] cnt_d;

   initial
   begin
      if (width < 4)
      begin
         $error("seq_timer width too small");
      end
   end

   always_comb
   begin
      cnt_d = cnt_q;
      if (load)
      begin
         cnt_d = count;
      end
      else if (cnt_q != '0)
      begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_q <= '0;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   // from the count alone; gating with load would close a loop through the sequencer
   assign done = (cnt_q == '0);
endmodule

// ===== verilog/pin_filter.sv
// hysteresis conditioning of the external reset pin
`timescale 1ns/1ns
module pin_filter
   import reset_seq_pkg::*;
#(
   parameter int depth = 4
)
(
   input wire logic hclk, // system clock
   input wire logic hresetn, // async reset, active low
   input wire logic pin_in, // raw pin level
   output logic pin_level // conditioned level
);
   logic [depth-1:0] hist_q;
   logic [depth-1:0] hist_d;
   logic level_q;
   logic level_d;

   initial
   begin
      if (depth < 2 || depth > 16)
      begin
         $error("pin_filter depth out of range");
      end
   end

   // level only flips once the whole history agrees, giving hysteresis
   always_comb
   begin
      hist_d = {hist_q[depth-2:0], pin_in};
      level_d = level_q;
      if (&hist_q)
      begin
         level_d = 1'b1;
      end
      else if (~|hist_q)
      begin
         level_d = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hist_q <= '1;
         level_q <= 1'b1;
      end
      else
      begin
         hist_q <= hist_d;
         level_q <= level_d;
      end
   end

   assign pin_level = level_q;
endmodule

// ===== tb/reset_seq_asserts.sv
// port assertions for the system reset sequencer
`timescale 1ns/1ns
module reset_seq_asserts
   import reset_seq_pkg::*;
#(
   parameter int warm_rc = rc_warm_cycles,
   parameter int warm_xtal = xtal_warm_cycles,
   parameter int filt_depth = 4
)
(
   input wire logic hclk, // system clock
   input wire logic hresetn, // async reset, active low
   input wire logic power_up, // power-on detect
   input wire logic supply_ok, // supply stable
   input wire logic low_voltage, // brown-out detect
   input wire logic wdt_overflow, // watchdog overflow
   input wire logic reset_n_pin, // reset pin
   input wire logic pin_enable, // pin function on
   input wire logic core_reset, // core hold
   input wire logic fetch_enable, // fetch allowed
   input wire logic [11:0] pc_start, // start address
   input wire logic low_power_n, // mode after boot
   input wire logic hreadyout, // slave ready
   input wire logic hresp // response
);
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // pin low long enough to pass the hysteresis filter
   sequence s_pin_low;
      (pin_enable && !reset_n_pin) [*8];
   endsequence
   sequence s_entry;
      $rose(core_reset);
   endsequence
   a_wdt_enters_reset: assert property (wdt_overflow |=> core_reset)
      else $error("watchdog overflow did not hold the core");
   a_power_enters_reset: assert property (power_up || low_voltage |=> core_reset)
      else $error("power source did not hold the core");
   a_supply_wait: assert property (!supply_ok |=> core_reset)
      else $error("core ran on an unstable supply");
   a_pin_holds_reset: assert property (s_pin_low |-> core_reset)
      else $error("low reset pin did not hold the core");
   a_fetch_halted: assert property (fetch_enable == !core_reset)
      else $error("fetch not halted in reset");
   a_pc_zero: assert property (pc_start == 12'h000)
      else $error("start address not zero");
   a_normal_mode: assert property ($fell(core_reset) |-> low_power_n)
      else $error("boot ended in low-power mode");
   a_sequence_span: assert property (s_entry |-> core_reset [*8])
      else $error("reset sequence too short");
   a_release_stable: assert property ($fell(core_reset) |-> supply_ok && $past(supply_ok))
      else $error("release without stable supply");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
endmodule
bind system_reset_sequencer reset_seq_asserts #(.warm_rc(warm_rc), .warm_xtal(warm_xtal),
   .filt_depth(filt_depth)) chk (.*);

// ===== tb/reset_sources.sv
// supply detector, watchdog and reset pin as seen by the sequencer
`timescale 1ns/1ns
module reset_sources
(
   input wire logic hclk, // system clock
   input wire logic power_cmd, // start a power-up ramp
   input wire logic wdt_cmd, // watchdog overflow request
   input wire logic pin_cmd, // press the reset pin
   input wire logic lowv_cmd, // drop below brown-out level
   input wire logic [1:0] lv_cmd, // supply flag levels
   output logic power_up, // power-on detect
   output logic supply_ok, // supply stable
   output logic low_voltage, // brown-out detect
   output logic lv_mid_in, // mid supply flag
   output logic lv_high_in, // high supply flag
   output logic wdt_overflow, // watchdog overflow
   output logic reset_n_pin // reset pin
);
   logic [3:0] ramp_q = 4'h0;
   always_ff @(posedge hclk)
      ramp_q <= power_cmd ? 4'hC : ramp_q - 4'(ramp_q != 4'h0);
   // supply counts as stable only late in the ramp
   assign power_up = ramp_q > 4'h8;
   assign supply_ok = ramp_q < 4'h5;
   assign low_voltage = lowv_cmd;
   assign lv_mid_in = lv_cmd[0];
   assign lv_high_in = lv_cmd[1];
   assign wdt_overflow = wdt_cmd;
   // pulled up whenever nobody presses it
   assign reset_n_pin = !pin_cmd;
endmodule

// ===== tb/tb_system_reset_sequencer.sv
// self-checking bench for the system reset sequencer
`timescale 1ns/1ns
module tb_system_reset_sequencer
   import reset_seq_pkg::*;
;
   localparam int wr = 8;
   localparam int wx = 20;
   localparam logic [31:0] flag_addr = {22'h0, flag_reg_offset, 2'b00};
   localparam logic [31:0] ctrl_addr = {22'h0, ctrl_reg_offset, 2'b00};
   localparam logic [31:0] stat_addr = {22'h0, stat_reg_offset, 2'b00};
   localparam logic [1:0] exp_cause [5] = '{cause_watchdog, cause_power, cause_power,
      cause_external, cause_external};
   logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
   logic [1:0] htrans = 2'h0, lv_cmd = 2'h0;
   logic power_cmd = 1'b0, wdt_cmd = 1'b0, pin_cmd = 1'b0, lowv_cmd = 1'b0;
   logic pin_enable = 1'b0, osc_xtal = 1'b0;
   logic hreadyout, hresp, power_up, supply_ok, low_voltage, lv_mid_in, lv_high_in;
   logic wdt_overflow, reset_n_pin, core_reset, fetch_enable, low_power_n;
   logic [11:0] pc_start;
   int fails = 0, total_checks = 0, n_rc, n_xt;
   always #4 hclk = ~hclk;
   system_reset_sequencer #(.warm_rc(wr), .warm_xtal(wx)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .power_up(power_up), .supply_ok(supply_ok), .low_voltage(low_voltage),
      .lv_mid_in(lv_mid_in), .lv_high_in(lv_high_in), .wdt_overflow(wdt_overflow),
      .reset_n_pin(reset_n_pin), .pin_enable(pin_enable), .osc_xtal(osc_xtal),
      .core_reset(core_reset), .pc_start(pc_start), .fetch_enable(fetch_enable),
      .low_power_n(low_power_n));
   reset_sources far (.hclk(hclk), .power_cmd(power_cmd), .wdt_cmd(wdt_cmd), .pin_cmd(pin_cmd),
      .lowv_cmd(lowv_cmd), .lv_cmd(lv_cmd), .power_up(power_up), .supply_ok(supply_ok),
      .low_voltage(low_voltage), .lv_mid_in(lv_mid_in), .lv_high_in(lv_high_in),
      .wdt_overflow(wdt_overflow), .reset_n_pin(reset_n_pin));
   task automatic end_sim;
      $display("checks %0d failures %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic step;
      int i;
      for (i = 0; i < 50; i++)
      begin
         @(posedge hclk);
         if (hreadyout === 1'b1)
            break;
      end
      if (i == 50)
      begin
         fails++;
         end_sim();
      end
   endtask
   task automatic bus(input logic wr_en, input logic [31:0] a, input logic [31:0] wd);
      hwrite <= wr_en;
      haddr <= a;
      htrans <= 2'h2;
      step();
      htrans <= 2'h0;
      hwdata <= wd;
      step();
      rd = hrdata;
   endtask
   // a long wait here means the sequence never let the core go
   task automatic boot(output int n);
      for (n = 0; n < 500 && core_reset !== 1'b0; n++)
         @(posedge hclk);
      if (n == 500)
      begin
         fails++;
         end_sim();
      end
   endtask
   task automatic sources(input int k);
      pin_enable <= (k != 4);
      wdt_cmd <= (k == 0);
      power_cmd <= (k == 1);
      lowv_cmd <= (k == 2);
      pin_cmd <= (k == 3 || k == 4);
   endtask
   task automatic kick(output int n);
      sources(0);
      @(posedge hclk);
      sources(9);
      repeat (2) @(posedge hclk);
      chk({31'h0, core_reset}, 32'h1, "watchdog pulse");
      boot(n);
   endtask
   initial
   begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      boot(n_rc);
      bus(1'b0, flag_addr, 32'h0);
      chk(rd, 32'h0000_00C0, "flag after reset");
      chk({18'h0, fetch_enable, low_power_n, pc_start}, 32'h0000_3000, "boot outputs");
      bus(1'b0, stat_addr, 32'h0);
      chk(rd, {26'h0, st_run}, "state after boot");
      bus(1'b1, ctrl_addr, 32'h1234_5678);
      bus(1'b0, ctrl_addr, 32'h0);
      chk(rd, 32'h1234_5678, "control write");
      lv_cmd <= 2'h3;
      bus(1'b1, flag_addr, 32'h0000_00FF);
      bus(1'b0, flag_addr, 32'h0);
      chk(rd, 32'h0000_00F7, "flag write");
      bus(1'b0, 32'h0000_0300, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      for (int k = 0; k < 5; k++)
      begin
         sources(k);
         repeat (8) @(posedge hclk);
         bus(1'b0, flag_addr, 32'h0);
         chk({31'h0, core_reset}, {31'h0, k != 4}, "held in reset");
         if (k == 2)
            chk({30'h0, rd[5:4]}, 32'h0, "supply flags");
         sources(9);
         // a pin enabled while its filter still reads low may start one more reset
         repeat (8) @(posedge hclk);
         boot(n_rc);
         bus(1'b0, flag_addr, 32'h0);
         chk({30'h0, rd[7:6]}, {30'h0, exp_cause[k]}, "cause");
         chk({29'h0, rd[2:0]}, 32'h0, "flags cleared");
      end
      bus(1'b0, ctrl_addr, 32'h0);
      chk(rd, ctrl_reset, "control cleared");
      kick(n_rc);
      osc_xtal <= 1'b1;
      kick(n_xt);
      chk(32'(n_xt - n_rc), 32'(wx - wr), "warm-up length");
      chk({31'h0, low_power_n}, 32'h1, "normal mode");
      end_sim();
   end
endmodule
